// >>> src/bsf_pkg.sv
/*
 Shared constants and types of the buck start-up and fault sequencer.
 Assumes a 100 MHz system clock. Every comparator flag arrives as one bit
 of a single flag vector.
*/
package bsf_pkg;

   localparam int CLK_PERIOD_NS = 10;

   // how long the output must stay low before a trip
   localparam int UV_DELAY_NS = 30000;
   localparam int UV_DELAY_CYC =
      (UV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int UV_CNT_W = 12;
   localparam logic [UV_CNT_W-1:0] UV_DELAY_LAST =
      UV_CNT_W'(UV_DELAY_CYC - 1);

   // default switching rate while the frequency-set pin is open
   localparam int SW_FREQ_KHZ = 200;
   localparam int SW_PERIOD_CYC =
      1000000 / (SW_FREQ_KHZ * CLK_PERIOD_NS);
   localparam int SW_CNT_W = 9;
   localparam logic [SW_CNT_W-1:0] SW_PERIOD_LAST =
      SW_CNT_W'(SW_PERIOD_CYC - 1);

   localparam logic [1:0] HICCUP_LIMIT = 2'h3;
   localparam logic [1:0] HICCUP_RESET = 2'h0;

   // bit positions in the flag vector
   localparam int FLAG_W = 10;
   localparam int F_VCC_OK = 0;
   localparam int F_SENSE_OK = 1;
   localparam int F_ENABLE = 2;
   localparam int F_RAMP_TOP = 3;
   localparam int F_RAMP_ARM = 4;
   localparam int F_RAMP_VALLEY = 5;
   localparam int F_RAMP_ZERO = 6;
   localparam int F_OUT_LOW = 7;
   localparam int F_SOFT_REF_LOW = 8;
   localparam int F_FREQ_OPEN = 9;

   localparam logic [FLAG_W-1:0] FLAG_RESET = 10'h000;

   typedef enum logic [1:0]
   {
      BSF_IDLE = 2'b00,
      BSF_SOFT = 2'b01,
      BSF_HICCUP = 2'b10,
      BSF_LATCHED = 2'b11
   } bsf_state_t;

endpackage

// >>> src/bsf_core_if.sv
/*
 Carrier between the synchroniser, the oscillator and the sequencer core.
 Assumes all three parties sit on the same clock.
*/
`timescale 1ns/1ns
interface bsf_core_if;
   logic [bsf_pkg::FLAG_W-1:0] flags;
   logic run;
   logic ext_tick;
   logic tick;

   modport sync_mp (output flags);
   modport osc_mp (input run, input ext_tick, input flags, output tick);
   modport core_mp (input flags, input tick, output run, output ext_tick);
endinterface

// >>> src/bsf_sync.sv
/*
 Two-stage synchroniser for the comparator flag vector.
 Assumes the flags are static levels from analog comparators.
*/
`timescale 1ns/1ns
module bsf_sync
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [bsf_pkg::FLAG_W-1:0] raw_i,
   bsf_core_if.sync_mp link
);
   typedef struct packed
   {
      logic [bsf_pkg::FLAG_W-1:0] meta;
      logic [bsf_pkg::FLAG_W-1:0] stable;
   } bsf_sync_st_t;

   bsf_sync_st_t st_r;
   bsf_sync_st_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.meta = raw_i;
      // first stage feeds the second stage only
      st_nxt.stable = st_r.meta;
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         st_r <= '{meta: bsf_pkg::FLAG_RESET, stable: bsf_pkg::FLAG_RESET};
      end
      else if (ce_i)
      begin
         st_r <= st_nxt;
      end
   end

   assign link.flags = st_r.stable;
endmodule

// >>> src/bsf_osc.sv
/*
 Switching-period tick: free-running 200 kHz default when the
 frequency-set pin is open, otherwise an externally timed tick.
 Assumes the external tick is a one-cycle pulse on the system clock.
*/
`timescale 1ns/1ns
module bsf_osc
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   bsf_core_if.osc_mp link
);
   typedef struct packed
   {
      logic [bsf_pkg::SW_CNT_W-1:0] cnt;
      logic tick;
   } bsf_osc_st_t;

   bsf_osc_st_t st_r;
   bsf_osc_st_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (!link.run)
      begin
         st_nxt.cnt = '0;
      end
      else if (link.flags[bsf_pkg::F_FREQ_OPEN])
      begin
         if (st_r.cnt == bsf_pkg::SW_PERIOD_LAST)
         begin
            st_nxt.cnt = '0;
            st_nxt.tick = 1'b1;
         end
         else
         begin
            st_nxt.cnt = st_r.cnt + 1'b1;
         end
      end
      else
      begin
         st_nxt.tick = link.ext_tick;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         st_r <= '{cnt: '0, tick: 1'b0};
      end
      else if (ce_i)
      begin
         st_r <= st_nxt;
      end
   end

   assign link.tick = st_r.tick;
endmodule

// >>> src/bsf_sequencer.sv
/*
 Start-up, soft-start and output-fault sequencer of a buck controller:
 readiness gating, ramp charge and discharge control, gate-drive enables,
 output undervoltage qualification, hiccup retries and latched shutdown.
 Assumes comparator flags from the analog side and a 100 MHz clock.
*/
// What this block does
// - start soft-start once supply, input, enable ready
// - input ready only above the sense threshold
// - enable low keeps both drivers off
// - rising enable after supplies starts soft-start
// - charge ramp during soft-start up to top
// - follow smaller of ramp and internal reference
// - force modulator low below sawtooth valley
// - lower switch off until upper switches
// - arm undervoltage only active and ramp high
// - trip after output low for 30us
// - hiccup first turns both drives off
// - hiccup discharges ramp, restarts at zero
// - retry soft-start re-trips on lasting short
// - latch off after three hiccups, supply releases
// - clear hiccup count on supply or enable loss
// - switch at 200kHz with pin open
`timescale 1ns/1ns
module bsf_sequencer
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic vcc_ok_i,
   input wire logic input_sense_pin_ok_i,
   input wire logic enable_i,
   input wire logic ramp_at_top_i,
   input wire logic ramp_above_arm_i,
   input wire logic ramp_above_valley_i,
   input wire logic ramp_at_zero_i,
   input wire logic output_low_trip_i,
   input wire logic ramp_reference_offset_low_i,
   input wire logic frequency_set_pin_open_i,
   input wire logic ext_switch_tick_i,
   output logic upper_drive_en_o,
   output logic lower_drive_en_o,
   output logic pwm_force_low_o,
   output logic soft_ref_select_o,
   output logic ramp_charge_o,
   output logic ramp_discharge_o,
   output logic switch_tick_o,
   output logic uv_armed_o,
   output logic in_hiccup_o,
   output logic latched_off_o,
   output logic [1:0] hiccup_count_o
);
   typedef struct packed
   {
      bsf_pkg::bsf_state_t state;
      logic [bsf_pkg::UV_CNT_W-1:0] uv_cnt;
      logic [1:0] hiccups;
      logic upper_started;
      logic upper_en;
      logic lower_en;
      logic force_low;
      logic soft_ref;
      logic charge;
      logic discharge;
      logic tick;
      logic armed;
   } bsf_seq_st_t;

   bsf_seq_st_t st_r;
   bsf_seq_st_t st_nxt;

   bsf_core_if core_link ();

   logic [bsf_pkg::FLAG_W-1:0] raw_flags;
   logic [bsf_pkg::FLAG_W-1:0] f;
   logic vcc_ok;
   logic enable;
   logic ready;
   logic uv_trip;

   always_comb
   begin
      raw_flags = bsf_pkg::FLAG_RESET;
      raw_flags[bsf_pkg::F_VCC_OK] = vcc_ok_i;
      raw_flags[bsf_pkg::F_SENSE_OK] = input_sense_pin_ok_i;
      raw_flags[bsf_pkg::F_ENABLE] = enable_i;
      raw_flags[bsf_pkg::F_RAMP_TOP] = ramp_at_top_i;
      raw_flags[bsf_pkg::F_RAMP_ARM] = ramp_above_arm_i;
      raw_flags[bsf_pkg::F_RAMP_VALLEY] = ramp_above_valley_i;
      raw_flags[bsf_pkg::F_RAMP_ZERO] = ramp_at_zero_i;
      raw_flags[bsf_pkg::F_OUT_LOW] = output_low_trip_i;
      raw_flags[bsf_pkg::F_SOFT_REF_LOW] = ramp_reference_offset_low_i;
      raw_flags[bsf_pkg::F_FREQ_OPEN] = frequency_set_pin_open_i;
   end

   // all comparator levels go through two stages first
   bsf_sync u_sync
   (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .raw_i(raw_flags),
      .link(core_link.sync_mp)
   );

   bsf_osc u_osc
   (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .link(core_link.osc_mp)
   );

   // oscillator only runs while the converter is soft-starting or running
   assign core_link.run = (st_r.state == bsf_pkg::BSF_SOFT);
   assign core_link.ext_tick = ext_switch_tick_i;

   assign f = core_link.flags;
   assign vcc_ok = f[bsf_pkg::F_VCC_OK];
   assign enable = f[bsf_pkg::F_ENABLE];
   // sense flag is the comparator above the input threshold
   assign ready = vcc_ok & f[bsf_pkg::F_SENSE_OK] & enable;

   // output must stay low for the full count while armed
   assign uv_trip = st_r.armed & f[bsf_pkg::F_OUT_LOW] &
      (st_r.uv_cnt == bsf_pkg::UV_DELAY_LAST);

   always_comb
   begin
      st_nxt = st_r;
      case (st_r.state)
         bsf_pkg::BSF_IDLE:
         begin
            st_nxt.upper_started = 1'b0;
            // no power-on order: whichever flag comes last starts it
            if (ready)
            begin
               st_nxt.state = bsf_pkg::BSF_SOFT;
            end
         end
         bsf_pkg::BSF_SOFT:
         begin
            if (!ready)
            begin
               st_nxt.state = bsf_pkg::BSF_IDLE;
            end
            else if (uv_trip)
            begin
               st_nxt.state = bsf_pkg::BSF_HICCUP;
               if (st_r.hiccups != bsf_pkg::HICCUP_LIMIT)
               begin
                  st_nxt.hiccups = st_r.hiccups + 1'b1;
               end
            end
         end
         bsf_pkg::BSF_HICCUP:
         begin
            st_nxt.upper_started = 1'b0;
            // ramp back at zero ends the hiccup
            if (f[bsf_pkg::F_RAMP_ZERO])
            begin
               if (st_r.hiccups == bsf_pkg::HICCUP_LIMIT)
               begin
                  st_nxt.state = bsf_pkg::BSF_LATCHED;
               end
               else
               begin
                  st_nxt.state = bsf_pkg::BSF_SOFT;
               end
            end
         end
         bsf_pkg::BSF_LATCHED:
         begin
            st_nxt.upper_started = 1'b0;
         end
         default:
         begin
            st_nxt.state = bsf_pkg::BSF_IDLE;
         end
      endcase

      // enable low drops a running converter; the latch needs supply loss
      if (!enable && st_r.state != bsf_pkg::BSF_LATCHED)
      begin
         st_nxt.state = bsf_pkg::BSF_IDLE;
      end
      if (!vcc_ok)
      begin
         st_nxt.state = bsf_pkg::BSF_IDLE;
      end
      if (!vcc_ok || !enable)
      begin
         st_nxt.hiccups = bsf_pkg::HICCUP_RESET;
      end

      // qualification counter restarts whenever the output recovers
      if (st_r.armed && f[bsf_pkg::F_OUT_LOW] && !uv_trip)
      begin
         st_nxt.uv_cnt = st_r.uv_cnt + 1'b1;
      end
      else
      begin
         st_nxt.uv_cnt = '0;
      end

      // first real pulse of the upper switch frees the lower one
      if (st_r.state == bsf_pkg::BSF_SOFT && core_link.tick &&
         f[bsf_pkg::F_RAMP_VALLEY])
      begin
         st_nxt.upper_started = 1'b1;
      end
      if (st_nxt.state != bsf_pkg::BSF_SOFT)
      begin
         st_nxt.upper_started = 1'b0;
      end

      // outputs follow the next state so they switch with it
      st_nxt.upper_en = (st_nxt.state == bsf_pkg::BSF_SOFT);
      st_nxt.lower_en = st_nxt.upper_en & st_nxt.upper_started;
      st_nxt.force_low = st_nxt.upper_en &
         !f[bsf_pkg::F_RAMP_VALLEY];
      st_nxt.soft_ref = st_nxt.upper_en &
         f[bsf_pkg::F_SOFT_REF_LOW];
      // source stops at the top level; the ramp then sits there
      st_nxt.charge = st_nxt.upper_en & !f[bsf_pkg::F_RAMP_TOP];
      st_nxt.discharge = (st_nxt.state == bsf_pkg::BSF_HICCUP) &
         !f[bsf_pkg::F_RAMP_ZERO];
      st_nxt.armed = st_nxt.upper_en & f[bsf_pkg::F_RAMP_ARM];
      st_nxt.tick = core_link.tick & st_nxt.upper_en;
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         st_r <= '{
            state: bsf_pkg::BSF_IDLE,
            uv_cnt: '0,
            hiccups: bsf_pkg::HICCUP_RESET,
            default: 1'b0
         };
      end
      else if (ce_i)
      begin
         st_r <= st_nxt;
      end
   end

   assign upper_drive_en_o = st_r.upper_en;
   assign lower_drive_en_o = st_r.lower_en;
   assign pwm_force_low_o = st_r.force_low;
   assign soft_ref_select_o = st_r.soft_ref;
   assign ramp_charge_o = st_r.charge;
   assign ramp_discharge_o = st_r.discharge;
   assign switch_tick_o = st_r.tick;
   assign uv_armed_o = st_r.armed;
   assign in_hiccup_o = (st_r.state == bsf_pkg::BSF_HICCUP);
   assign latched_off_o = (st_r.state == bsf_pkg::BSF_LATCHED);
   assign hiccup_count_o = st_r.hiccups;
endmodule

// >>> sim/bsf_sequencer_properties.sv
/*
 Temporal checks on the buck start-up sequencer top ports.
 Assumes ce_i held high, so a flag acts three edges after it changes.
*/
`timescale 1ns/1ns
module bsf_seq_checker
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic vcc_ok_i,
   input wire logic input_sense_pin_ok_i,
   input wire logic enable_i,
   input wire logic ramp_at_top_i,
   input wire logic ramp_above_valley_i,
   input wire logic ramp_at_zero_i,
   input wire logic output_low_trip_i,
   input wire logic ramp_reference_offset_low_i,
   input wire logic upper_drive_en_o,
   input wire logic soft_ref_select_o,
   input wire logic switch_tick_o,
   input wire logic lower_drive_en_o,
   input wire logic pwm_force_low_o,
   input wire logic ramp_charge_o,
   input wire logic ramp_discharge_o,
   input wire logic uv_armed_o,
   input wire logic in_hiccup_o,
   input wire logic latched_off_o,
   input wire logic [1:0] hiccup_count_o
);
   // sync lag lets the raw run differ a few cycles from the core count
   localparam int UV_LO = bsf_pkg::UV_DELAY_CYC - 4;
   localparam int UV_HI = bsf_pkg::UV_DELAY_CYC + 4;
   logic [12:0] low_cnt_r;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   always_ff @(posedge clock_i)
      low_cnt_r <= (rst_i || !(uv_armed_o && output_low_trip_i)) ?
         13'h0000 : low_cnt_r + 13'h0001;
   sequence en_low3;
      !enable_i [*3];
   endsequence
   sequence valley_low3;
      !ramp_above_valley_i [*3];
   endsequence
   sequence ref_low3;
      ramp_reference_offset_low_i [*3];
   endsequence
   sequence trip_seen;
      $rose(in_hiccup_o);
   endsequence
   chk_start_ready: assert property ($rose(upper_drive_en_o) |->
      $past(vcc_ok_i, 3) && $past(input_sense_pin_ok_i, 3)
      && $past(enable_i, 3)) else $error("drive on before ready");
   chk_enable_off: assert property (en_low3 |=>
      !upper_drive_en_o && !lower_drive_en_o) else $error("drive on");
   chk_charge_stop: assert property (ramp_at_top_i [*3] |=>
      !ramp_charge_o) else $error("charging past top");
   chk_valley_hold: assert property (valley_low3 ##1 upper_drive_en_o
      |-> pwm_force_low_o) else $error("modulator not held low");
   chk_lower_after: assert property ($rose(lower_drive_en_o) |->
      upper_drive_en_o && $past(upper_drive_en_o)) else $error("lower early");
   chk_trip_late: assert property (trip_seen |->
      low_cnt_r >= UV_LO) else $error("trip before delay");
   chk_trip_bound: assert property (low_cnt_r <= UV_HI)
      else $error("no trip after delay");
   chk_hiccup_entry: assert property (trip_seen |-> !upper_drive_en_o
      && !lower_drive_en_o && !ramp_charge_o && ramp_discharge_o)
      else $error("bad hiccup entry");
   chk_hiccup_exit: assert property ($fell(in_hiccup_o) |->
      $past(ramp_at_zero_i, 3) || !$past(vcc_ok_i, 3) || !$past(enable_i, 3))
      else $error("hiccup left early");
   chk_latch_entry: assert property ($rose(latched_off_o) |->
      $past(in_hiccup_o) && hiccup_count_o == 2'h3) else $error("bad latch");
   chk_latch_hold: assert property (latched_off_o && vcc_ok_i
      && $past(vcc_ok_i) |=> latched_off_o) else $error("latch released");
   chk_count_clear: assert property (en_low3 |=>
      hiccup_count_o == 2'h0) else $error("hiccup count kept");
   chk_soft_ref: assert property (ref_low3 ##1 upper_drive_en_o
      |-> soft_ref_select_o) else $error("soft reference not selected");
   chk_tick_pulse: assert property (switch_tick_o |->
      upper_drive_en_o ##1 !switch_tick_o) else $error("bad switch tick");
endmodule

bind bsf_sequencer bsf_seq_checker u_chk (.clock_i, .rst_i, .vcc_ok_i,
   .input_sense_pin_ok_i, .enable_i, .ramp_at_top_i, .ramp_above_valley_i,
   .ramp_at_zero_i, .output_low_trip_i, .ramp_reference_offset_low_i,
   .upper_drive_en_o, .lower_drive_en_o, .soft_ref_select_o, .switch_tick_o,
   .pwm_force_low_o, .ramp_charge_o, .ramp_discharge_o, .uv_armed_o,
   .in_hiccup_o, .latched_off_o, .hiccup_count_o);

// >>> sim/bsf_analog_model.sv
/*
 Behavioural ramp capacitor and comparators facing the sequencer.
 Assumes one ramp step per clock while charging or discharging.
*/
`timescale 1ns/1ns
module bsf_analog_model
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic charge_i,
   input wire logic discharge_i,
   input wire logic short_i,
   output logic top_o,
   output logic arm_o,
   output logic valley_o,
   output logic zero_o,
   output logic ref_low_o,
   output logic out_low_o
);
   localparam int TOP = 100;
   localparam int ARM = 80;
   localparam int VALLEY = 10;
   localparam int REF = 40;
   logic [6:0] ramp_r;
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         ramp_r <= 7'h00;
      else if (charge_i && ramp_r < TOP)
         ramp_r <= ramp_r + 7'h01;
      else if (discharge_i && ramp_r != 7'h00)
         ramp_r <= ramp_r - 7'h01;
   end
   assign top_o = ramp_r >= TOP;
   assign arm_o = ramp_r > ARM;
   assign valley_o = ramp_r > VALLEY;
   assign zero_o = ramp_r == 7'h00;
   assign ref_low_o = ramp_r < REF;
   assign out_low_o = short_i;
endmodule

// >>> sim/tb.sv
/*
 Self-checking bench: notes expected drive states, a watcher compares.
 Assumes the analog model stands for the ramp and feedback comparators.
*/
`timescale 1ns/1ns
module tb;
   logic clock_i, rst_i, vcc_ok, sense_ok, enable, short_on;
   logic top, arm, valley, zero, ref_low, out_low;
   logic upper, lower, hiccup, latched, charge, discharge;
   logic [1:0] count;
   logic [5:0] exp_q[$];
   logic [5:0] seen_r, want, obs;
   int err_total, n_compared, seed, i;
   assign obs = {count, latched, hiccup, upper, lower};
   bsf_analog_model u_ana (.clock_i, .rst_i, .charge_i(charge),
      .discharge_i(discharge), .short_i(short_on), .top_o(top), .arm_o(arm),
      .valley_o(valley), .zero_o(zero), .ref_low_o(ref_low),
      .out_low_o(out_low));
   bsf_sequencer dut (.clock_i, .rst_i, .ce_i(1'b1), .vcc_ok_i(vcc_ok),
      .input_sense_pin_ok_i(sense_ok), .enable_i(enable),
      .ramp_at_top_i(top), .ramp_above_arm_i(arm),
      .ramp_above_valley_i(valley), .ramp_at_zero_i(zero),
      .output_low_trip_i(out_low), .ramp_reference_offset_low_i(ref_low),
      .frequency_set_pin_open_i(1'b1), .ext_switch_tick_i(1'b0),
      .upper_drive_en_o(upper), .lower_drive_en_o(lower),
      .pwm_force_low_o(), .soft_ref_select_o(), .ramp_charge_o(charge),
      .ramp_discharge_o(discharge), .switch_tick_o(), .uv_armed_o(),
      .in_hiccup_o(hiccup), .latched_off_o(latched), .hiccup_count_o(count));
   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   task automatic note(input logic [5:0] v);
      exp_q.push_back(v);
   endtask
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic drain(input int lim, input string what);
      int k;
      k = 0;
      while (exp_q.size() != 0 && k < lim)
      begin
         cyc(1);
         k++;
      end
      cyc(20);
      n_compared++;
      if (exp_q.size() != 0)
      begin
         err_total++;
         $display("CHECK FAILED %s pending expected 0 seen %0d", what,
            exp_q.size());
      end
      $display("test %s done", what);
   endtask
   // each change of the drive state consumes the oldest note
   // sampled mid-cycle so the registered outputs have settled
   always @(negedge clock_i)
   begin
      if (rst_i)
         seen_r = 6'h00;
      else if (obs !== seen_r)
      begin
         want = exp_q.size() != 0 ? exp_q.pop_front() : 6'hxx;
         n_compared++;
         if (obs !== want)
         begin
            err_total++;
            $display("CHECK FAILED drive state expected %h seen %h", want,
               obs);
         end
         seen_r = obs;
      end
   end
   initial
   begin
      cyc(60000);
      err_total++;
      $display("watchdog expired");
      give_verdict();
   end
   initial
   begin
      {rst_i, vcc_ok, sense_ok, enable, short_on} = 5'h10;
      {err_total, n_compared, seed} = {32'h0, 32'h0, 32'h5};
      cyc(4);
      rst_i <= 1'b0;
      vcc_ok <= 1'b1;
      enable <= 1'b1;
      drain(60, "sense_low");
      note(6'h02);
      note(6'h03);
      sense_ok <= 1'b1;
      drain(1500, "start");
      for (i = 0; i < 5; i++)
      begin
         short_on <= 1'b1;
         cyc(1000 + int'({$random(seed)} % 1800));
         short_on <= 1'b0;
         cyc(10);
      end
      drain(1, "short_glitch");
      note(6'h14);
      note(6'h12);
      note(6'h13);
      note(6'h24);
      note(6'h22);
      note(6'h23);
      note(6'h34);
      note(6'h38);
      short_on <= 1'b1;
      drain(20000, "hiccup_latch");
      cyc(300);
      note(6'h08);
      enable <= 1'b0;
      drain(50, "count_clear");
      note(6'h00);
      vcc_ok <= 1'b0;
      drain(50, "supply_release");
      short_on <= 1'b0;
      vcc_ok <= 1'b1;
      drain(50, "enable_low_hold");
      note(6'h02);
      note(6'h03);
      enable <= 1'b1;
      drain(1500, "enable_start");
      note(6'h00);
      enable <= 1'b0;
      drain(50, "enable_drop");
      give_verdict();
   end
endmodule
